// ==== adcseq_map.svh ====
`ifndef ADCSEQ_MAP_SVH
`define ADCSEQ_MAP_SVH

// Register byte addresses
`define ADCSEQ_ADDR_CTRL0 12'h000
`define ADCSEQ_ADDR_CTRL1 12'h004
`define ADCSEQ_ADDR_APEL 12'h008
`define ADCSEQ_ADDR_APEH 12'h00C
`define ADCSEQ_ADDR_ISTAT 12'h010
`define ADCSEQ_ADDR_IMASK 12'h014

// Control 0 fields
`define ADCSEQ_C0_START 7
`define ADCSEQ_C0_BUSY 6
`define ADCSEQ_C0_POFF 5
`define ADCSEQ_C0_FMT 4
`define ADCSEQ_C0_CHLO_MSB 3
`define ADCSEQ_C0_RESET 8'h60

// Control 1 fields
`define ADCSEQ_C1_CHTOP 7
`define ADCSEQ_C1_BGEN 6
`define ADCSEQ_C1_REFSEL 4
`define ADCSEQ_C1_DIV_MSB 2
`define ADCSEQ_C1_WMASK 8'hD7
`define ADCSEQ_C1_RESET 8'h00

`define ADCSEQ_APEL_RESET 8'h00
`define ADCSEQ_APEH_WMASK 8'h03
`define ADCSEQ_APEH_RESET 8'h00

// Conversion timing in converter clock cycles; divider stop code and top count
`define ADCSEQ_SAMPLE_CYC 5'd4
`define ADCSEQ_TOTAL_CYC 5'd16
`define ADCSEQ_DIV_STOP 3'h7
`define ADCSEQ_DIV_MAXCNT 6'h3F

`endif

// ==== adcseq_pkg.sv ====
package adcseq_pkg;
    typedef enum logic [1:0] {
        ADCSEQ_IDLE = 2'b00,
        ADCSEQ_HELD = 2'b01,
        ADCSEQ_SAMPLE = 2'b10,
        ADCSEQ_CONVERT = 2'b11
    } adcseq_state_type;
endpackage

// ==== adcseq_clkdiv.sv ====
`include "adcseq_map.svh"

module adcseq_clkdiv
    import adcseq_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_clear,
    input wire logic [2:0] i_div_code,
    output logic o_tick
);
    logic [5:0] cnt_reg;
    logic [5:0] cnt_next;
    logic [5:0] limit;

    always_comb begin
        limit = 6'h00;
        cnt_next = cnt_reg;
        o_tick = 1'b0;
        // Divide by 2**code for codes 0-6, code 7 stops; one-cycle enable per period
        case (i_div_code)
            3'h0: limit = 6'h00;
            3'h1: limit = 6'h01;
            3'h2: limit = 6'h03;
            3'h3: limit = 6'h07;
            3'h4: limit = 6'h0F;
            3'h5: limit = 6'h1F;
            3'h6: limit = `ADCSEQ_DIV_MAXCNT;
            default: limit = 6'h00;
        endcase
        if (i_clear || i_div_code == `ADCSEQ_DIV_STOP) begin
            cnt_next = 6'h00;
        end else if (cnt_reg >= limit) begin
            cnt_next = 6'h00;
            o_tick = 1'b1;
        end else begin
            cnt_next = cnt_reg + 6'h01;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            cnt_reg <= 6'h00;
        end else begin
            cnt_reg <= cnt_next;
        end
    end
endmodule

// ==== adcseq_top.sv ====
// Function
// - Reference select: supply when 0, pin when 1
// - External reference disables other pin functions
// - Control 1 bit 3 reads zero
// - Divide code picks clock divide 1 to 64
// - Bandgap on when enabled, else grounded
// - Low enables make pins 0-7 analog
// - High enables channels 8,9; rest read zero
// - Start pulse rise then fall begins conversion
// - Start high holds reset, busy forced one
// - Busy clears when conversion finishes
// - Completion sets interrupt flag, raises interrupt when mask set
// - Conversion is 4 sample plus 12 cycles
// - Busy read-only, resets to one
// - Power off bit, one is off, resets one
// - Channel top bit routes bandgap, drops pins
//
// Decided for this implementation: the placing of the registers and register access over APB.
`include "adcseq_map.svh"

module adcseq_top
    import adcseq_pkg::*;
(
    input wire logic I_MCLK,
    input wire logic I_RST_N,
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic [11:0] I_PADDR,
    input wire logic [31:0] I_PWDATA,
    input wire logic [3:0] I_PSTRB,
    output logic [31:0] O_PRDATA,
    output logic O_PREADY,
    output logic O_PSLVERR,
    input wire logic I_LV_SUPERVISOR_EN,
    output logic O_REF_SELECT,
    output logic O_REF_PIN_EXCLUSIVE,
    output logic O_BANDGAP_ON,
    output logic O_BANDGAP_REF_ON,
    output logic O_BANDGAP_TO_ADC,
    output logic [9:0] O_ANALOG_PIN_EN,
    output logic [9:0] O_CHANNEL_ROUTE,
    output logic O_CONV_RESET,
    output logic O_CONV_POWER_ON,
    output logic O_CONV_CLK_EN,
    output logic O_SAMPLING,
    output logic O_CONV_DONE,
    output logic O_RESULT_FORMAT,
    output logic O_IRQ
);
    logic [7:0] ctrl0_reg;
    logic [7:0] ctrl0_next;
    logic [7:0] ctrl1_reg;
    logic [7:0] ctrl1_next;
    logic [7:0] apel_reg;
    logic [7:0] apel_next;
    logic [1:0] apeh_reg;
    logic [1:0] apeh_next;
    logic istat_reg;
    logic istat_next;
    logic imask_reg;
    logic imask_next;
    adcseq_state_type state_reg;
    adcseq_state_type state_next;
    logic [4:0] cyc_reg;
    logic [4:0] cyc_next;
    logic busy_reg;
    logic busy_next;
    logic done_reg;
    logic done_next;
    logic start_bit;
    logic start_fall;
    logic tick;
    logic wr_en;
    logic rd_en;
    logic addr_ok;
    logic [7:0] wbyte;
    logic [7:0] rd_byte;
    logic [3:0] ch_low;

    function automatic logic addr_mapped(input logic [11:0] a);
        addr_mapped = (a == `ADCSEQ_ADDR_CTRL0) || (a == `ADCSEQ_ADDR_CTRL1) ||
            (a == `ADCSEQ_ADDR_APEL) || (a == `ADCSEQ_ADDR_APEH) ||
            (a == `ADCSEQ_ADDR_ISTAT) || (a == `ADCSEQ_ADDR_IMASK);
    endfunction

    // Zero-wait APB slave
    assign addr_ok = addr_mapped(I_PADDR);
    assign wr_en = I_PSEL && I_PENABLE && I_PWRITE && addr_ok && I_PSTRB[0];
    assign rd_en = I_PSEL && !I_PWRITE && addr_ok;
    assign wbyte = I_PWDATA[7:0];
    assign O_PREADY = 1'b1;
    assign O_PSLVERR = I_PSEL && I_PENABLE && !addr_ok;

    assign start_bit = ctrl0_reg[`ADCSEQ_C0_START];

    always_comb begin
        ctrl0_next = ctrl0_reg;
        ctrl1_next = ctrl1_reg;
        apel_next = apel_reg;
        apeh_next = apeh_reg;
        imask_next = imask_reg;
        istat_next = istat_reg;
        start_fall = 1'b0;
        if (wr_en) begin
            case (I_PADDR)
                `ADCSEQ_ADDR_CTRL0: begin
                    // Busy bit is never written by software
                    ctrl0_next = {wbyte[7], ctrl0_reg[6], wbyte[5:0]};
                    start_fall = start_bit && !wbyte[7];
                end
                `ADCSEQ_ADDR_CTRL1: ctrl1_next = wbyte & `ADCSEQ_C1_WMASK;
                `ADCSEQ_ADDR_APEL: apel_next = wbyte;
                `ADCSEQ_ADDR_APEH: apeh_next = wbyte[1:0];
                `ADCSEQ_ADDR_IMASK: imask_next = wbyte[0];
                `ADCSEQ_ADDR_ISTAT: begin
                    if (wbyte[0]) begin
                        istat_next = 1'b0;
                    end
                end
                default: ctrl0_next = ctrl0_reg;
            endcase
        end
        // Completion wins over a same-cycle clear
        if (done_reg) begin
            istat_next = 1'b1;
        end
        ctrl0_next[`ADCSEQ_C0_BUSY] = busy_next;
    end

    // Conversion sequencer
    always_comb begin
        state_next = state_reg;
        cyc_next = cyc_reg;
        busy_next = busy_reg;
        done_next = 1'b0;
        if (start_bit && !start_fall) begin
            state_next = ADCSEQ_HELD;
            busy_next = 1'b1;
            cyc_next = 5'd0;
        end else begin
            case (state_reg)
                ADCSEQ_HELD: begin
                    if (start_fall) begin
                        state_next = ADCSEQ_SAMPLE;
                        cyc_next = 5'd0;
                    end
                end
                ADCSEQ_SAMPLE: begin
                    if (tick && O_CONV_POWER_ON) begin
                        cyc_next = cyc_reg + 5'd1;
                        if (cyc_reg + 5'd1 == `ADCSEQ_SAMPLE_CYC) begin
                            state_next = ADCSEQ_CONVERT;
                        end
                    end
                end
                ADCSEQ_CONVERT: begin
                    if (tick && O_CONV_POWER_ON) begin
                        cyc_next = cyc_reg + 5'd1;
                        if (cyc_reg + 5'd1 == `ADCSEQ_TOTAL_CYC) begin
                            state_next = ADCSEQ_IDLE;
                            busy_next = 1'b0;
                            done_next = 1'b1;
                            cyc_next = 5'd0;
                        end
                    end
                end
                default: state_next = ADCSEQ_IDLE;
            endcase
        end
    end

    adcseq_clkdiv u_div (
        .i_clk(I_MCLK),
        .i_rst_n(I_RST_N),
        .i_clear(state_reg == ADCSEQ_HELD || state_reg == ADCSEQ_IDLE),
        .i_div_code(ctrl1_reg[`ADCSEQ_C1_DIV_MSB:0]),
        .o_tick(tick)
    );

    always_ff @(posedge I_MCLK) begin
        if (!I_RST_N) begin
            ctrl0_reg <= `ADCSEQ_C0_RESET;
            ctrl1_reg <= `ADCSEQ_C1_RESET;
            apel_reg <= `ADCSEQ_APEL_RESET;
            apeh_reg <= 2'b00;
            istat_reg <= 1'b0;
            imask_reg <= 1'b0;
            state_reg <= ADCSEQ_IDLE;
            cyc_reg <= 5'd0;
            busy_reg <= 1'b1;
            done_reg <= 1'b0;
        end else begin
            ctrl0_reg <= ctrl0_next;
            ctrl1_reg <= ctrl1_next;
            apel_reg <= apel_next;
            apeh_reg <= apeh_next;
            istat_reg <= istat_next;
            imask_reg <= imask_next;
            state_reg <= state_next;
            cyc_reg <= cyc_next;
            busy_reg <= busy_next;
            done_reg <= done_next;
        end
    end

    // Read mux, unimplemented bits read zero
    always_comb begin
        rd_byte = 8'h00;
        case (I_PADDR)
            `ADCSEQ_ADDR_CTRL0: rd_byte = ctrl0_reg;
            `ADCSEQ_ADDR_CTRL1: rd_byte = ctrl1_reg & `ADCSEQ_C1_WMASK;
            `ADCSEQ_ADDR_APEL: rd_byte = apel_reg;
            `ADCSEQ_ADDR_APEH: rd_byte = {6'h00, apeh_reg};
            `ADCSEQ_ADDR_ISTAT: rd_byte = {7'h00, istat_reg};
            `ADCSEQ_ADDR_IMASK: rd_byte = {7'h00, imask_reg};
            default: rd_byte = 8'h00;
        endcase
        O_PRDATA = rd_en ? {24'h00_0000, rd_byte} : 32'h0000_0000;
    end

    assign ch_low = ctrl0_reg[`ADCSEQ_C0_CHLO_MSB:0];

    // Outputs decoded from control state
    assign O_REF_SELECT = ctrl1_reg[`ADCSEQ_C1_REFSEL];
    assign O_REF_PIN_EXCLUSIVE = ctrl1_reg[`ADCSEQ_C1_REFSEL];
    assign O_BANDGAP_ON = ctrl1_reg[`ADCSEQ_C1_BGEN];
    assign O_BANDGAP_REF_ON = ctrl1_reg[`ADCSEQ_C1_BGEN] || I_LV_SUPERVISOR_EN;
    assign O_BANDGAP_TO_ADC = ctrl1_reg[`ADCSEQ_C1_CHTOP];
    assign O_ANALOG_PIN_EN = {apeh_reg, apel_reg};
    // Codes above 9 all select channel 9
    always_comb begin
        O_CHANNEL_ROUTE = 10'h000;
        if (!ctrl1_reg[`ADCSEQ_C1_CHTOP]) begin
            if (ch_low > 4'h9) begin
                O_CHANNEL_ROUTE[9] = 1'b1;
            end else begin
                O_CHANNEL_ROUTE[ch_low] = 1'b1;
            end
        end
    end
    assign O_CONV_RESET = start_bit;
    assign O_CONV_POWER_ON = !ctrl0_reg[`ADCSEQ_C0_POFF];
    assign O_CONV_CLK_EN = tick;
    // State lags the start bit a cycle; mask sampling at once
    assign O_SAMPLING = state_reg == ADCSEQ_SAMPLE && !start_bit;
    assign O_CONV_DONE = done_reg;
    assign O_RESULT_FORMAT = ctrl0_reg[`ADCSEQ_C0_FMT];
    assign O_IRQ = istat_reg && imask_reg;
endmodule

// ==== adcseq_monitor.sv ====
module adcseq_monitor (
    input wire logic I_MCLK,
    input wire logic I_RST_N,
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic [11:0] I_PADDR,
    input wire logic [31:0] I_PWDATA,
    input wire logic [3:0] I_PSTRB,
    input wire logic [31:0] O_PRDATA,
    input wire logic O_REF_SELECT,
    input wire logic O_BANDGAP_TO_ADC,
    input wire logic [9:0] O_ANALOG_PIN_EN,
    input wire logic [9:0] O_CHANNEL_ROUTE,
    input wire logic O_CONV_RESET,
    input wire logic O_CONV_POWER_ON,
    input wire logic O_CONV_CLK_EN,
    input wire logic O_SAMPLING,
    input wire logic O_CONV_DONE
);
    timeunit 1ns;
    timeprecision 1ps;
    logic wr;
    logic [4:0] cnt_reg;
    logic [4:0] cnt_next;
    assign wr = I_PSEL && I_PENABLE && I_PWRITE && I_PSTRB[0];
    // Ticks since start released; saturates so idle ticks cannot wrap
    always_comb begin
        cnt_next = cnt_reg;
        if (O_CONV_RESET)
            cnt_next = 5'h0;
        else if (O_CONV_CLK_EN && O_CONV_POWER_ON && cnt_reg != 5'h1F)
            cnt_next = cnt_reg + 5'h1;
    end
    always_ff @(posedge I_MCLK) begin
        cnt_reg <= I_RST_N ? cnt_next : 5'h0;
    end
    default clocking @(posedge I_MCLK); endclocking
    default disable iff (!I_RST_N);
    a_ref_write: assert property (
        wr && I_PADDR == 12'h004 |=> O_REF_SELECT == $past(I_PWDATA[4]))
        else $error("Reference select wrong");
    a_bit3_zero: assert property (
        I_PSEL && !I_PWRITE && I_PADDR == 12'h004 |-> O_PRDATA[3] == 1'b0)
        else $error("Control 1 bit 3 not zero");
    a_pin_low: assert property (
        wr && I_PADDR == 12'h008 |=> O_ANALOG_PIN_EN[7:0] == $past(I_PWDATA[7:0]))
        else $error("Low pin enables wrong");
    a_pin_high: assert property (
        wr && I_PADDR == 12'h00C |=> O_ANALOG_PIN_EN[9:8] == $past(I_PWDATA[1:0]))
        else $error("High pin enables wrong");
    a_high_unused: assert property (
        I_PSEL && !I_PWRITE && I_PADDR == 12'h00C |-> O_PRDATA[7:2] == 6'h00)
        else $error("High enable unused bits set");
    a_start_hold: assert property (
        O_CONV_RESET |-> !O_SAMPLING && !O_CONV_DONE)
        else $error("Converter runs while held");
    a_route_bg: assert property (
        O_BANDGAP_TO_ADC |-> O_CHANNEL_ROUTE == 10'h000)
        else $error("Channel routed with bandgap");
    a_done_count: assert property (
        O_CONV_DONE |-> cnt_reg == 5'h10)
        else $error("Conversion length not 16 ticks");
    a_sample_span: assert property (
        O_SAMPLING |-> cnt_reg < 5'h4)
        else $error("Sampling longer than 4 ticks");
    cover property (O_CONV_DONE);
    cover property (O_SAMPLING && O_CONV_CLK_EN);
    cover property (O_BANDGAP_TO_ADC);
endmodule

bind adcseq_top adcseq_monitor u_mon (.I_MCLK, .I_RST_N, .I_PSEL, .I_PENABLE, .I_PWRITE,
    .I_PADDR, .I_PWDATA, .I_PSTRB, .O_PRDATA, .O_REF_SELECT, .O_BANDGAP_TO_ADC,
    .O_ANALOG_PIN_EN, .O_CHANNEL_ROUTE, .O_CONV_RESET, .O_CONV_POWER_ON,
    .O_CONV_CLK_EN, .O_SAMPLING, .O_CONV_DONE);

// ==== test_adc_control_sequencer.sv ====
module test_adc_control_sequencer;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic pen = 1'b0;
    logic pwr = 1'b0;
    logic sup = 1'b0;
    logic [11:0] pa = 12'h000;
    logic [31:0] pd = 32'h0000_0000;
    logic [31:0] prd;
    logic rdy, err, rsel, rx, bgon, bgref, bgadc, crst, pon, tick, smp, done, irq, fmt;
    logic [3:0] strb = 4'hF;
    logic [9:0] pins, route;
    logic [32:0] q[$];
    int failures = 0;
    int checked = 0;
    always #2.5 clk = ~clk;
    adcseq_top uut (.I_MCLK(clk), .I_RST_N(rst_n), .I_PSEL(psel), .I_PENABLE(pen),
        .I_PWRITE(pwr), .I_PADDR(pa), .I_PWDATA(pd), .I_PSTRB(strb), .O_PRDATA(prd),
        .O_PREADY(rdy), .O_PSLVERR(err), .I_LV_SUPERVISOR_EN(sup), .O_REF_SELECT(rsel),
        .O_REF_PIN_EXCLUSIVE(rx), .O_BANDGAP_ON(bgon), .O_BANDGAP_REF_ON(bgref),
        .O_BANDGAP_TO_ADC(bgadc), .O_ANALOG_PIN_EN(pins), .O_CHANNEL_ROUTE(route),
        .O_CONV_RESET(crst), .O_CONV_POWER_ON(pon), .O_CONV_CLK_EN(tick), .O_SAMPLING(smp),
        .O_CONV_DONE(done), .O_RESULT_FORMAT(fmt), .O_IRQ(irq));
    task chk(input logic [32:0] s, input logic [32:0] e);
        checked++;
        if (s !== e) begin
            $display("Error at %0t: seen %h expected %h", $time, s, e);
            failures++;
        end
    endtask
    task give_verdict;
        $display("Comparisons %0d, mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [7:0] d, input logic [32:0] e);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        pa <= a;
        pd <= {24'h00_0000, d};
        @(posedge clk);
        pen <= 1'b1;
        if (!w) q.push_back(e);
        do begin
            @(posedge clk);
            n++;
        end while (rdy !== 1'b1 && n < 64);
        if (rdy !== 1'b1) begin
            failures++;
            give_verdict();
        end
        psel <= 1'b0;
        pen <= 1'b0;
        #1;
    endtask
    // Read data judged where the access completes, against the oldest note
    always @(posedge clk) begin
        if (psel && pen && !pwr && rdy === 1'b1) chk({err, prd}, q.pop_front());
    end
    task conv(input int d, input logic m);
        int k, nt, tf, tl, ns;
        nt = 0;
        ns = 0;
        tf = 0;
        tl = 0;
        apb(1, 12'h014, {7'h00, m}, 0);
        apb(1, 12'h004, d[7:0], 0);
        apb(1, 12'h000, 8'h80, 0);
        chk(crst, 1);
        apb(0, 12'h000, 0, 33'h0_0000_00C0);
        apb(1, 12'h000, 8'h00, 0);
        for (k = 0; k < 3000; k++) begin
            if (done === 1'b1) break;
            if (tick === 1'b1) begin
                if (smp === 1'b1) ns++;
                if (nt == 0) tf = k;
                tl = k;
                nt++;
            end
            @(posedge clk);
            #1;
        end
        if (k == 3000) begin
            failures++;
            give_verdict();
        end
        chk(nt, 16);
        chk(ns, 4);
        chk(tl - tf, 15 << d);
        @(posedge clk);
        #1;
        chk(irq, m);
        apb(0, 12'h010, 0, 1);
        apb(0, 12'h000, 0, 0);
        apb(1, 12'h010, 8'h01, 0);
        chk(irq, 0);
        $display("Conversion test code %0d done", d);
    endtask
    initial begin
        int i, k, r;
        r = $urandom(56365);
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        chk(pon, 0);
        apb(0, 12'h000, 0, 33'h0_0000_0060);
        apb(0, 12'h00C, 0, 0);
        apb(0, 12'h020, 0, 33'h1_0000_0000);
        // Write with lane 0 off must leave the register alone
        @(posedge clk);
        strb <= 4'hE;
        apb(1, 12'h008, 8'hFF, 0);
        @(posedge clk);
        strb <= 4'hF;
        apb(0, 12'h008, 0, 0);
        $display("Reset test done");
        for (i = 0; i < 4; i++) begin
            r = $urandom;
            r[7] = i[0];
            r[6] = i[0];
            r[4] = i[1];
            @(posedge clk);
            sup <= i[1];
            apb(1, 12'h004, r[7:0], 0);
            chk({rsel, rx}, {2{r[4]}});
            chk({bgon, bgref}, {r[6], r[6] | i[1]});
            apb(0, 12'h004, 0, r[7:0] & 8'hD7);
            apb(1, 12'h000, {3'h0, r[24], r[3:0]}, 0);
            apb(0, 12'h000, 0, {2'b01, 1'b0, r[24], r[3:0]});
            chk({fmt, bgadc, route},
                {r[24], r[7], r[7] ? 10'h000 : 10'h001 << (r[3:0] > 4'h9 ? 4'h9 : r[3:0])});
            apb(1, 12'h008, r[15:8], 0);
            apb(1, 12'h00C, r[23:16], 0);
            chk(pins, {r[17:16], r[15:8]});
            apb(0, 12'h00C, 0, r[23:16] & 8'h03);
        end
        $display("Register test done");
        // Codes 0 to 6 run; the period range is software's care
        for (i = 0; i < 7; i++) conv(i, i != 0);
        apb(1, 12'h004, 8'h07, 0);
        apb(1, 12'h000, 8'h80, 0);
        apb(1, 12'h000, 8'h00, 0);
        k = 0;
        repeat (200) begin
            @(posedge clk);
            #1;
            if (tick === 1'b1 || done === 1'b1) k++;
        end
        chk(k, 0);
        apb(0, 12'h000, 0, 33'h0_0000_0040);
        $display("Stopped clock test done");
        give_verdict();
    end
endmodule
